// >>> rtl/tmc_top.sv
`include "tmc_cfg.svh"

module tmc_top #(
  parameter int PRESCALE_DIV = `TMC_PRESCALE_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // special-function-register bus
  input wire tmc_pkg::tmc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // count and gate pins
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic timer2_count_pin,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  // flags and events
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic timer2_overflow_flag,
  output logic timer1_baud_tick,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  output logic adc_start_pulse
);

  logic [7:0] timer01_control_reg, timer01_mode_config, clock_control_reg;
  logic [7:0] timer2_control_reg;
  logic [7:0] timer0_low_byte, timer0_high_byte, timer1_low_r, timer1_high_r;
  logic [7:0] timer2_count_low, timer2_count_high;
  logic [7:0] rdata_r;
  logic [3:0] pre_cnt_r;
  logic div2_r;
  logic t1_baud_r, tx_baud_r, rx_baud_r, adc_r;
  logic [`TMC_PIN_COUNT-1:0] pin_lvl, pin_fall;

  tmc_pin_sync #(
    .N(`TMC_PIN_COUNT)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_raw({ext_irq1_pin, ext_irq0_pin, timer2_count_pin, timer1_count_pin,
      timer0_count_pin}),
    .pin_lvl(pin_lvl),
    .pin_fall(pin_fall)
  );

  function automatic logic wr_hit(input tmc_pkg::tmc_sfr_req_t r, input logic [7:0] a);
    return r.wr_en && (r.addr == a);
  endfunction : wr_hit

  // count source: pin edge, full system clock or the divide-by-twelve tick
  function automatic logic src_tick(input logic csel, input logic pre, input logic fall,
    input logic t12);
    return csel ? fall : (pre ? 1'b1 : t12);
  endfunction : src_tick

  // one count step of a basic timer; bit 16 is the overflow
  function automatic logic [16:0] step01(input tmc_pkg::tmc_t01_mode_t md,
    input logic [7:0] lo, input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (md)
      tmc_pkg::MODE_13BIT:
      begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == 5'h1f)
          r[16:8] = {1'b0, hi} + 9'h001;
      end
      tmc_pkg::MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
      tmc_pkg::MODE_8BIT_RELOAD:
      begin
        if (lo == 8'hff)
          r = {1'b1, hi, hi};
        else
          r[7:0] = lo + 8'h01;
      end
      default:
      begin
        r[16] = (lo == 8'hff);
        r[7:0] = lo + 8'h01;
      end
    endcase
    return r;
  endfunction : step01

  function automatic tmc_pkg::tmc_tmr2_mode_t tmr2_decode(input logic [7:0] c);
    if (!c[`TMC_B_TMR2_RUN])
      return tmc_pkg::TMR2_OFF;
    case ({c[`TMC_B_TMR2_RXBAUD], c[`TMC_B_TMR2_TXBAUD]})
      2'b01: return tmc_pkg::TMR2_BAUD_TX;
      2'b10: return tmc_pkg::TMR2_BAUD_RX;
      2'b11: return tmc_pkg::TMR2_BAUD_TXRX;
      default: return c[`TMC_B_TMR2_CAPT] ? tmc_pkg::TMR2_CAPTURE : tmc_pkg::TMR2_RELOAD;
    endcase
  endfunction : tmr2_decode

  // shared prescalers
  logic tick12;
  assign tick12 = (pre_cnt_r == 4'(PRESCALE_DIV - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pre_cnt_r <= 4'h0;
      div2_r <= 1'b0;
    end
    else
    begin
      pre_cnt_r <= tick12 ? 4'h0 : pre_cnt_r + 4'h1;
      div2_r <= ~div2_r;
    end
  end

  // timer 0 and 1 enables and steps
  tmc_pkg::tmc_t01_mode_t t0_md, t1_md;
  logic t0_split, run0, tick0, tick_h0, run1, tick1;
  logic [16:0] step0, step1;
  logic [8:0] h0_step;
  logic t0_ovf, h0_ovf, t1_ovf, tf1_set;

  assign t0_md = tmc_pkg::tmc_t01_mode_t'(timer01_mode_config[`TMC_F_TMR0_MODE]);
  assign t1_md = tmc_pkg::tmc_t01_mode_t'(timer01_mode_config[`TMC_F_TMR1_MODE]);
  assign t0_split = (t0_md == tmc_pkg::MODE_SPLIT);
  assign run0 = timer01_control_reg[`TMC_B_TMR0_RUN]
    & (~timer01_mode_config[`TMC_B_TMR0_GATE] | pin_lvl[`TMC_PIN_IRQ0]);
  assign tick0 = run0 & src_tick(timer01_mode_config[`TMC_B_TMR0_CSEL],
    clock_control_reg[`TMC_B_TMR0_PRE], pin_fall[`TMC_PIN_TMR0], tick12);
  assign step0 = step01(t0_md, timer0_low_byte, timer0_high_byte);
  assign t0_ovf = tick0 & step0[16];
  // high byte in split mode: internal clock only, enabled by timer 1 run
  assign tick_h0 = t0_split & timer01_control_reg[`TMC_B_TMR1_RUN]
    & src_tick(1'b0, clock_control_reg[`TMC_B_TMR0_PRE], 1'b0, tick12);
  assign h0_step = {1'b0, timer0_high_byte} + 9'h001;
  assign h0_ovf = tick_h0 & h0_step[8];
  // timer 1 loses its run bit and pin to timer 0 while timer 0 is split
  assign run1 = (t1_md != tmc_pkg::MODE_SPLIT) & (t0_split
    | (timer01_control_reg[`TMC_B_TMR1_RUN]
    & (~timer01_mode_config[`TMC_B_TMR1_GATE] | pin_lvl[`TMC_PIN_IRQ1])));
  assign tick1 = run1 & src_tick(timer01_mode_config[`TMC_B_TMR1_CSEL] & ~t0_split,
    clock_control_reg[`TMC_B_TMR1_PRE], pin_fall[`TMC_PIN_TMR1], tick12);
  assign step1 = step01(t1_md, timer1_low_r, timer1_high_r);
  assign t1_ovf = tick1 & step1[16];
  assign tf1_set = t0_split ? h0_ovf : t1_ovf;

  // timer 2
  tmc_pkg::tmc_tmr2_mode_t tmr2_md;
  logic tmr2_baud, tick2, tmr2_ovf;
  logic [16:0] tmr2_next;

  assign tmr2_md = tmr2_decode(timer2_control_reg);
  assign tmr2_baud = (tmr2_md == tmc_pkg::TMR2_BAUD_TX) || (tmr2_md == tmc_pkg::TMR2_BAUD_RX)
    || (tmr2_md == tmc_pkg::TMR2_BAUD_TXRX);
  // baud generation runs from half the system clock unless the pin is chosen
  assign tick2 = (tmr2_md != tmc_pkg::TMR2_OFF) & (timer2_control_reg[`TMC_B_TMR2_CSEL]
    ? pin_fall[`TMC_PIN_TMR2] : (tmr2_baud ? div2_r
    : src_tick(1'b0, clock_control_reg[`TMC_B_TMR2_PRE], 1'b0, tick12)));
  assign tmr2_next = {1'b0, timer2_count_high, timer2_count_low} + 17'h00001;
  assign tmr2_ovf = tick2 & tmr2_next[16];

  // control registers; a hardware set beats a software clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      timer01_control_reg <= `TMC_RST_VAL;
      timer2_control_reg <= `TMC_RST_VAL;
      timer01_mode_config <= `TMC_RST_VAL;
      clock_control_reg <= `TMC_RST_VAL;
    end
    else
    begin
      if (wr_hit(sfr_req, `TMC_ADDR_TMR01_CTL))
        timer01_control_reg <= sfr_req.wdata;
      if (t0_ovf)
        timer01_control_reg[`TMC_B_TMR0_OVF] <= 1'b1;
      if (tf1_set)
        timer01_control_reg[`TMC_B_TMR1_OVF] <= 1'b1;
      if (wr_hit(sfr_req, `TMC_ADDR_TMR2_CTL))
        timer2_control_reg <= sfr_req.wdata;
      if (tmr2_ovf && !tmr2_baud)
        timer2_control_reg[`TMC_B_TMR2_OVF] <= 1'b1;
      if (wr_hit(sfr_req, `TMC_ADDR_TMR01_MODE))
        timer01_mode_config <= sfr_req.wdata;
      if (wr_hit(sfr_req, `TMC_ADDR_CLK_CTL))
        clock_control_reg <= sfr_req.wdata;
    end
  end

  // count registers; a software write wins over a count in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      timer0_low_byte <= `TMC_RST_VAL;
      timer0_high_byte <= `TMC_RST_VAL;
      timer1_low_r <= `TMC_RST_VAL;
      timer1_high_r <= `TMC_RST_VAL;
      timer2_count_low <= `TMC_RST_VAL;
      timer2_count_high <= `TMC_RST_VAL;
    end
    else
    begin
      if (wr_hit(sfr_req, `TMC_ADDR_TMR0_LOW))
        timer0_low_byte <= sfr_req.wdata;
      else if (tick0)
        timer0_low_byte <= step0[7:0];
      if (wr_hit(sfr_req, `TMC_ADDR_TMR0_HIGH))
        timer0_high_byte <= sfr_req.wdata;
      else if (tick_h0)
        timer0_high_byte <= h0_step[7:0];
      else if (tick0 && !t0_split)
        timer0_high_byte <= step0[15:8];
      if (wr_hit(sfr_req, `TMC_ADDR_TMR1_LOW))
        timer1_low_r <= sfr_req.wdata;
      else if (tick1)
        timer1_low_r <= step1[7:0];
      if (wr_hit(sfr_req, `TMC_ADDR_TMR1_HIGH))
        timer1_high_r <= sfr_req.wdata;
      else if (tick1)
        timer1_high_r <= step1[15:8];
      // there is no reload source, so reload mode wraps to zero like every other mode
      if (wr_hit(sfr_req, `TMC_ADDR_TMR2_LOW))
        timer2_count_low <= sfr_req.wdata;
      else if (tick2)
        timer2_count_low <= tmr2_next[7:0];
      if (wr_hit(sfr_req, `TMC_ADDR_TMR2_HIGH))
        timer2_count_high <= sfr_req.wdata;
      else if (tick2)
        timer2_count_high <= tmr2_next[15:8];
    end
  end

  // event pulses
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      t1_baud_r <= 1'b0;
      tx_baud_r <= 1'b0;
      rx_baud_r <= 1'b0;
      adc_r <= 1'b0;
    end
    else
    begin
      t1_baud_r <= t1_ovf;
      tx_baud_r <= tmr2_ovf && (tmr2_md == tmc_pkg::TMR2_BAUD_TX
        || tmr2_md == tmc_pkg::TMR2_BAUD_TXRX);
      rx_baud_r <= tmr2_ovf && (tmr2_md == tmc_pkg::TMR2_BAUD_RX
        || tmr2_md == tmc_pkg::TMR2_BAUD_TXRX);
      adc_r <= tmr2_ovf;
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdata_r <= 8'h00;
    else if (!sfr_req.rd_en)
      rdata_r <= 8'h00;
    else
    begin
      case (sfr_req.addr)
        `TMC_ADDR_TMR01_CTL: rdata_r <= timer01_control_reg;
        `TMC_ADDR_TMR01_MODE: rdata_r <= timer01_mode_config;
        `TMC_ADDR_TMR0_LOW: rdata_r <= timer0_low_byte;
        `TMC_ADDR_TMR1_LOW: rdata_r <= timer1_low_r;
        `TMC_ADDR_TMR0_HIGH: rdata_r <= timer0_high_byte;
        `TMC_ADDR_TMR1_HIGH: rdata_r <= timer1_high_r;
        `TMC_ADDR_CLK_CTL: rdata_r <= clock_control_reg;
        `TMC_ADDR_TMR2_CTL: rdata_r <= timer2_control_reg;
        `TMC_ADDR_TMR2_LOW: rdata_r <= timer2_count_low;
        `TMC_ADDR_TMR2_HIGH: rdata_r <= timer2_count_high;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = rdata_r;
  assign timer0_overflow_flag = timer01_control_reg[`TMC_B_TMR0_OVF];
  assign timer1_overflow_flag = timer01_control_reg[`TMC_B_TMR1_OVF];
  assign timer2_overflow_flag = timer2_control_reg[`TMC_B_TMR2_OVF];
  assign timer1_baud_tick = t1_baud_r;
  assign tx_baud_tick = tx_baud_r;
  assign rx_baud_tick = rx_baud_r;
  assign adc_start_pulse = adc_r;

  chk_run_off_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!timer2_control_reg[`TMC_B_TMR2_RUN] && !sfr_req.wr_en)
    |=> $stable({timer2_count_high, timer2_count_low}))
    else $error("timer 2 moved while off");
  chk_prescale_gap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tick12 |=> !tick12 [*8])
    else $error("prescale tick too soon");
  chk_pin_edge_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pin_fall[`TMC_PIN_TMR2] && timer2_control_reg[`TMC_B_TMR2_CSEL]
    && timer2_control_reg[`TMC_B_TMR2_RUN] && !sfr_req.wr_en)
    |=> !$stable({timer2_count_high, timer2_count_low}))
    else $error("timer 2 missed pin edge");
  chk_adc_strobe: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tmr2_ovf |=> adc_start_pulse ##1 (!adc_start_pulse || $past(tmr2_ovf)))
    else $error("converter strobe wrong");
  chk_baud_no_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tmr2_baud && tmr2_ovf && !timer2_overflow_flag) |=> !timer2_overflow_flag)
    else $error("baud mode set overflow flag");
  chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tmr2_ovf && !tmr2_baud) |=> timer2_overflow_flag)
    else $error("timer 2 overflow flag lost");
  chk_gate_blocks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (timer01_mode_config[`TMC_B_TMR0_GATE] && !pin_lvl[`TMC_PIN_IRQ0] && !sfr_req.wr_en)
    |=> $stable(timer0_low_byte))
    else $error("gated timer 0 counted");
  chk_t1_stopped: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (t1_md == tmc_pkg::MODE_SPLIT && !sfr_req.wr_en)
    |=> $stable({timer1_high_r, timer1_low_r}))
    else $error("timer 1 counted in mode 3");
  chk_split_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (t0_split && h0_ovf) |=> timer1_overflow_flag)
    else $error("high byte overflow lost");

endmodule : tmc_top

// >>> rtl/tmc_cfg.svh
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// register offsets on the special-function-register bus
`define TMC_ADDR_TMR01_CTL 8'h88
`define TMC_ADDR_TMR01_MODE 8'h89
`define TMC_ADDR_TMR0_LOW 8'h8a
`define TMC_ADDR_TMR1_LOW 8'h8b
`define TMC_ADDR_TMR0_HIGH 8'h8c
`define TMC_ADDR_TMR1_HIGH 8'h8d
`define TMC_ADDR_CLK_CTL 8'h8e
`define TMC_ADDR_TMR2_CTL 8'hc8
`define TMC_ADDR_TMR2_LOW 8'hcc
`define TMC_ADDR_TMR2_HIGH 8'hcd

// reset value shared by every register
`define TMC_RST_VAL 8'h00

// timer 0/1 control register bits
`define TMC_B_TMR1_OVF 7
`define TMC_B_TMR1_RUN 6
`define TMC_B_TMR0_OVF 5
`define TMC_B_TMR0_RUN 4

// timer 0/1 mode register fields
`define TMC_B_TMR1_GATE 7
`define TMC_B_TMR1_CSEL 6
`define TMC_F_TMR1_MODE 5:4
`define TMC_B_TMR0_GATE 3
`define TMC_B_TMR0_CSEL 2
`define TMC_F_TMR0_MODE 1:0

// clock control register bits
`define TMC_B_TMR0_PRE 3
`define TMC_B_TMR1_PRE 4
`define TMC_B_TMR2_PRE 5

// timer 2 control register bits
`define TMC_B_TMR2_OVF 7
`define TMC_B_TMR2_RXBAUD 5
`define TMC_B_TMR2_TXBAUD 4
`define TMC_B_TMR2_RUN 2
`define TMC_B_TMR2_CSEL 1
`define TMC_B_TMR2_CAPT 0

// system clock prescale when the divide bit is clear
`define TMC_PRESCALE_DIV 12

// pin order on the synchroniser
`define TMC_PIN_TMR0 0
`define TMC_PIN_TMR1 1
`define TMC_PIN_TMR2 2
`define TMC_PIN_IRQ0 3
`define TMC_PIN_IRQ1 4
`define TMC_PIN_COUNT 5

`endif

// >>> rtl/tmc_pkg.sv
package tmc_pkg;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmc_sfr_req_t;

  // encoding order matches the two-bit mode field
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8BIT_RELOAD,
    MODE_SPLIT
  } tmc_t01_mode_t;

  typedef enum logic [2:0] {
    TMR2_OFF,
    TMR2_CAPTURE,
    TMR2_RELOAD,
    TMR2_BAUD_TX,
    TMR2_BAUD_RX,
    TMR2_BAUD_TXRX
  } tmc_tmr2_mode_t;

endpackage : tmc_pkg

// >>> rtl/tmc_pin_sync.sv
module tmc_pin_sync #(
  parameter int N = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // raw pins
  input wire logic [N-1:0] pin_raw,
  // synchronised level and falling edge
  output logic [N-1:0] pin_lvl,
  output logic [N-1:0] pin_fall
);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  // first stage feeds only the second, to keep metastability contained
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end
    else
    begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pin_lvl = sync_r;
  assign pin_fall = prev_r & ~sync_r;

endmodule : tmc_pin_sync

// >>> sim/tmc_pin_model.sv
module tmc_pin_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // requests from the bench
  input wire logic [2:0] fall_req,
  input wire logic [1:0] irq_lvl,
  // pins toward the block
  output logic [2:0] count_pin,
  output logic [1:0] irq_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hold_r [3];

  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!rst_b)
        hold_r[i] <= 2'h0;
      else if (fall_req[i])
        hold_r[i] <= 2'h3;
      else if (hold_r[i] != 2'h0)
        hold_r[i] <= hold_r[i] - 2'h1;
    end
  end

  // idle high like a pulled-up pin; low for three cycles so the synchroniser sees it
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      count_pin[i] = (hold_r[i] == 2'h0);
  end

  assign irq_pin = irq_lvl;
endmodule : tmc_pin_model

// >>> sim/timer_mode_control_tb.sv
`include "tmc_cfg.svh"

module timer_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  tmc_pkg::tmc_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic [2:0] fall_req = 3'h0;
  logic [1:0] irq_lvl = 2'h0;
  logic [2:0] count_pin;
  logic [1:0] irq_pin;
  logic t0_ovf, t1_ovf, tmr2_ovf, t1_baud, tx_baud, rx_baud, adc_start;
  logic [2:0] flags;
  logic rd_taken = 1'b0;
  logic [7:0] exp_q [$];
  int failures = 0;
  int checked = 0;
  int n_t1 = 0;
  int n_tx = 0;
  int n_rx = 0;
  int n_adc = 0;
  logic [7:0] regs [10] = '{`TMC_ADDR_TMR01_CTL, `TMC_ADDR_TMR01_MODE, `TMC_ADDR_TMR0_LOW,
    `TMC_ADDR_TMR1_LOW, `TMC_ADDR_TMR0_HIGH, `TMC_ADDR_TMR1_HIGH, `TMC_ADDR_CLK_CTL,
    `TMC_ADDR_TMR2_CTL, `TMC_ADDR_TMR2_LOW, `TMC_ADDR_TMR2_HIGH};
  logic [7:0] modes [6] = '{8'h05, 8'h04, 8'h15, 8'h24, 8'h35, 8'h31};
  logic [7:0] ex_tx [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0] ex_rx [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  logic [7:0] ex_adc [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [7:0] ex_flg [6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  assign flags = {tmr2_ovf, t1_ovf, t0_ovf};
  always #50 ref_clk = ~ref_clk;

  tmc_top u_tmc_top (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .timer0_count_pin(count_pin[0]),
    .timer1_count_pin(count_pin[1]),
    .timer2_count_pin(count_pin[2]),
    .ext_irq0_pin(irq_pin[0]),
    .ext_irq1_pin(irq_pin[1]),
    .timer0_overflow_flag(t0_ovf),
    .timer1_overflow_flag(t1_ovf),
    .timer2_overflow_flag(tmr2_ovf),
    .timer1_baud_tick(t1_baud),
    .tx_baud_tick(tx_baud),
    .rx_baud_tick(rx_baud),
    .adc_start_pulse(adc_start)
  );

  tmc_pin_model u_tmc_pin_model (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .fall_req(fall_req),
    .irq_lvl(irq_lvl),
    .count_pin(count_pin),
    .irq_pin(irq_pin)
  );

  task automatic finish_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp

  task automatic cmp_rng(input string what, input int lo, input int hi, input int s);
    checked++;
    if (s < lo || s > hi)
    begin
      failures++;
      $display("MISMATCH %s expected %0d to %0d seen %0d", what, lo, hi, s);
    end
  endtask : cmp_rng

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
  endtask : sfr_wr

  // the expectation is queued now and consumed when the read data appears
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    exp_q.push_back(e);
  endtask : sfr_rd

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      sfr_req <= '0;
    end
  endtask : idle

  task automatic tmr2_load(input logic [15:0] v);
    sfr_wr(`TMC_ADDR_TMR2_LOW, v[7:0]);
    sfr_wr(`TMC_ADDR_TMR2_HIGH, v[15:8]);
  endtask : tmr2_load

  task automatic pin_fall();
    @(posedge ref_clk);
    fall_req <= 3'h4;
    @(posedge ref_clk);
    fall_req <= 3'h0;
    idle(8);
  endtask : pin_fall

  task automatic wait_flag(input int i, input int lim);
    checked++;
    for (int k = 0; k < lim; k++)
    begin
      @(negedge ref_clk);
      if (flags[i] === 1'b1)
        return;
    end
    failures++;
    $display("MISMATCH flag %0d expected 1 seen 0", i);
    finish_test();
  endtask : wait_flag

  always @(posedge ref_clk)
    rd_taken <= sfr_req.rd_en;

  always @(negedge ref_clk)
  begin
    if (rd_taken)
      cmp("sfr_rdata", exp_q.pop_front(), sfr_rdata);
    if (t1_baud === 1'b1)
      n_t1++;
    if (tx_baud === 1'b1)
      n_tx++;
    if (rx_baud === 1'b1)
      n_rx++;
    if (adc_start === 1'b1)
      n_adc++;
  end

  initial
  begin
    #1ms;
    failures++;
    $display("MISMATCH watchdog expected done seen running");
    finish_test();
  end

  initial
  begin
    logic [7:0] r;
    void'($urandom(1029));
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (regs[i])
      sfr_rd(regs[i], 8'h00);
    sfr_rd(8'h90, 8'h00);
    for (int i = 2; i < 10; i++)
    begin
      if (i == 6 || i == 7)
        continue;
      r = 8'($urandom());
      sfr_wr(regs[i], r);
      sfr_rd(regs[i], r);
    end
    r = 8'($urandom());
    sfr_wr(`TMC_ADDR_TMR01_MODE, r);
    sfr_rd(`TMC_ADDR_TMR01_MODE, r);
    sfr_wr(`TMC_ADDR_TMR01_MODE, 8'h00);
    // undivided clock: wrap, flag and converter start land on fixed cycles
    tmr2_load(16'hffff);
    sfr_wr(`TMC_ADDR_CLK_CTL, 8'h20);
    sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h04);
    idle(2);
    @(negedge ref_clk);
    cmp("adc_start_pulse", 8'h01, {7'h0, adc_start});
    cmp("timer2 flag", 8'h01, {7'h0, tmr2_ovf});
    @(negedge ref_clk);
    cmp("adc_start_pulse low", 8'h00, {7'h0, adc_start});
    sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h00);
    // divide by twelve: sixteen counts take 180 to 192 cycles
    sfr_wr(`TMC_ADDR_CLK_CTL, 8'h00);
    tmr2_load(16'hfff0);
    n_adc = 0;
    sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h04);
    idle(170);
    cmp("adc early", 8'h00, 8'(n_adc));
    idle(40);
    cmp("adc late", 8'h01, 8'(n_adc));
    sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h00);
    sfr_wr(`TMC_ADDR_CLK_CTL, 8'h20);
    foreach (modes[i])
    begin
      tmr2_load(16'hffff);
      n_tx = 0;
      n_rx = 0;
      n_adc = 0;
      sfr_wr(`TMC_ADDR_TMR2_CTL, modes[i]);
      idle(10);
      cmp("tx ticks", ex_tx[i], 8'(n_tx));
      cmp("rx ticks", ex_rx[i], 8'(n_rx));
      cmp("adc starts", ex_adc[i], 8'(n_adc));
      @(negedge ref_clk);
      cmp("timer2 flag mode", ex_flg[i], {7'h0, tmr2_ovf});
      sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h00);
    end
    // counter select: only pin edges advance the count
    tmr2_load(16'hfffb);
    n_adc = 0;
    sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h06);
    idle(4);
    for (int i = 0; i < 4; i++)
      pin_fall();
    cmp("adc after four edges", 8'h00, 8'(n_adc));
    pin_fall();
    cmp("adc after five edges", 8'h01, 8'(n_adc));
    sfr_wr(`TMC_ADDR_TMR2_CTL, 8'h00);
    // gated timer 0 waits for its interrupt pin
    sfr_wr(`TMC_ADDR_TMR0_LOW, 8'hff);
    sfr_wr(`TMC_ADDR_TMR0_HIGH, 8'hff);
    sfr_wr(`TMC_ADDR_CLK_CTL, 8'h08);
    sfr_wr(`TMC_ADDR_TMR01_MODE, 8'h09);
    sfr_wr(`TMC_ADDR_TMR01_CTL, 8'h10);
    idle(12);
    @(negedge ref_clk);
    cmp("timer0 flag gated", 8'h00, {7'h0, t0_ovf});
    @(posedge ref_clk);
    irq_lvl <= 2'h1;
    wait_flag(0, 12);
    sfr_wr(`TMC_ADDR_TMR01_CTL, 8'h00);
    // split timer 0, timer 1 in reload mode with period sixteen
    sfr_wr(`TMC_ADDR_TMR0_LOW, 8'hff);
    sfr_wr(`TMC_ADDR_TMR0_HIGH, 8'hff);
    sfr_wr(`TMC_ADDR_TMR1_LOW, 8'hf0);
    sfr_wr(`TMC_ADDR_TMR1_HIGH, 8'hf0);
    sfr_wr(`TMC_ADDR_CLK_CTL, 8'h18);
    n_t1 = 0;
    sfr_wr(`TMC_ADDR_TMR01_MODE, 8'h23);
    sfr_wr(`TMC_ADDR_TMR01_CTL, 8'h10);
    idle(1);
    wait_flag(0, 12);
    idle(160);
    @(negedge ref_clk);
    cmp("timer1 flag", 8'h00, {7'h0, t1_ovf});
    cmp_rng("timer1 baud ticks", 9, 12, n_t1);
    sfr_wr(`TMC_ADDR_TMR01_CTL, 8'h50);
    idle(1);
    wait_flag(1, 12);
    // timer 1 in its own mode 3 stops, so its baud ticks cease
    sfr_wr(`TMC_ADDR_TMR01_MODE, 8'h33);
    idle(2);
    n_t1 = 0;
    idle(40);
    cmp_rng("timer1 stopped", 0, 0, n_t1);
    idle(2);
    finish_test();
  end
endmodule : timer_mode_control_tb
